// ### hw/sensor_config_register.sv
// Purpose: Configuration word, lock protection, shutdown and event output.
// Assumes: The serial decoder gives one-cycle read and write strobes.
// Notes:   Limits and the converter sit outside; this block gates them.
`timescale 1ns/1ps
`default_nettype none
module sensor_config_register
  import sensor_cfg_pkg::*;
#(
  parameter int W = TEMP_W
) (
  // Clock, reset and clock enable
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Register access from the serial port
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  input  wire logic [7:0]   i_ptr,
  input  wire logic [15:0]  i_wdata,
  output logic [15:0]       o_rdata,
  output logic              o_rd_valid,
  // Conversion engine and limits
  input  wire logic         i_conv_valid,
  input  wire logic [W-1:0] i_conv_temp,
  input  wire limits_type   i_limits,
  output logic              o_conv_enable,
  output logic [W-1:0]      o_ambient_temp_value,
  // Lock state for the limit registers
  output logic              o_crit_lock,
  output logic              o_win_lock,
  // Event pin level after polarity
  output logic              o_event
);
  cfg_type        cfg_q;
  cfg_type        cfg_d;
  logic [W-1:0]   amb_q;
  logic [W-1:0]   amb_d;
  logic           int_flag_q;
  logic           int_flag_d;
  logic           win_prev_q;
  logic           win_prev_d;
  logic           ev_q;
  logic           ev_d;
  logic [15:0]    rdata_q;
  logic [15:0]    rdata_d;
  logic           rdv_q;
  logic           rdv_d;
  logic           cfg_wr;
  logic           locked;
  logic [W-1:0]   hyst_amount;
  logic           up_trip;
  logic           lo_trip;
  logic           cr_trip;
  logic           win_cond;

  assign cfg_wr = i_wr && (i_ptr == CFG_PTR);
  assign locked = cfg_q.crit_lock || cfg_q.win_lock;

  always_comb begin
    case (cfg_q.hyst)
      HC_NONE: hyst_amount = HYST_0P0; // [R3]
      HC_1P5:  hyst_amount = HYST_1P5; // [R2]
      HC_3P0:  hyst_amount = HYST_3P0; // [R2]
      default: hyst_amount = HYST_6P0; // [R2]
    endcase
  end

  hyst_comparator #(.W(W), .ABOVE(1'b1), .INCLUSIVE(1'b0)) u_upper (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_temp  (amb_q),
    .i_limit (i_limits.upper),
    .i_hyst  (hyst_amount),
    .o_trip  (up_trip)
  );
  hyst_comparator #(.W(W), .ABOVE(1'b0), .INCLUSIVE(1'b0)) u_lower (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_temp  (amb_q),
    .i_limit (i_limits.lower),
    .i_hyst  (hyst_amount),
    .o_trip  (lo_trip)
  );
  hyst_comparator #(.W(W), .ABOVE(1'b1), .INCLUSIVE(1'b1)) u_crit (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_temp  (amb_q),
    .i_limit (i_limits.crit),
    .i_hyst  (hyst_amount),
    .o_trip  (cr_trip)
  );

  assign win_cond = !cfg_q.ev_sel && (up_trip || lo_trip);

  // Configuration word with lock protection.
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      if (!locked) begin
        cfg_d.hyst    = i_wdata[HYST_HI:HYST_LO]; // [R4] [R5]
        cfg_d.ev_en   = i_wdata[EV_EN_BIT];
        cfg_d.ev_pol  = i_wdata[EV_POL_BIT];
        cfg_d.ev_mode = i_wdata[EV_MODE_BIT];
      end
      if (!cfg_q.win_lock) begin
        cfg_d.ev_sel = i_wdata[EV_SEL_BIT];
      end
      // Shutdown may always be left, but only entered while unlocked.
      if (!i_wdata[SHUTDOWN_SELECT_BIT]) begin
        cfg_d.shutdown_select = 1'b0; // [R10]
      end else if (!locked) begin
        cfg_d.shutdown_select = 1'b1; // [R6] [R9]
      end
      // Lock bits stick until reset.
      cfg_d.crit_lock = cfg_q.crit_lock || i_wdata[CRIT_LK_BIT];
      cfg_d.win_lock  = cfg_q.win_lock || i_wdata[WIN_LK_BIT];
    end
  end

  // Ambient value, event flags and event output.
  always_comb begin
    amb_d      = amb_q;
    if (i_conv_valid && !cfg_q.shutdown_select) begin
      amb_d = i_conv_temp; // [R7] [R11]
    end
    win_prev_d = win_cond;
    int_flag_d = int_flag_q;
    if (cfg_wr && i_wdata[INT_CLR_BIT]) begin
      int_flag_d = 1'b0;
    end
    // A new window crossing in the clear cycle still sets the flag.
    if (!cfg_q.shutdown_select && win_cond && !win_prev_q) begin
      int_flag_d = 1'b1;
    end
    ev_d = !cfg_q.shutdown_select && cfg_q.ev_en
           && (cr_trip || (cfg_q.ev_mode ? int_flag_q : win_cond)); // [R8]
  end

  // Read path; other pointers read as zero from this block.
  always_comb begin
    rdata_d = rdata_q;
    rdv_d   = i_rd;
    if (i_rd) begin
      rdata_d = 16'h0000; // [R1]
      if (i_ptr == CFG_PTR) begin
        rdata_d[HYST_HI:HYST_LO] = cfg_q.hyst;
        rdata_d[SHUTDOWN_SELECT_BIT]        = cfg_q.shutdown_select;
        rdata_d[CRIT_LK_BIT]     = cfg_q.crit_lock;
        rdata_d[WIN_LK_BIT]      = cfg_q.win_lock;
        rdata_d[EV_STAT_BIT]     = ev_q;
        rdata_d[EV_EN_BIT]       = cfg_q.ev_en;
        rdata_d[EV_SEL_BIT]      = cfg_q.ev_sel;
        rdata_d[EV_POL_BIT]      = cfg_q.ev_pol;
        rdata_d[EV_MODE_BIT]     = cfg_q.ev_mode;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // The struct packs fields densely, so only a reset word with bits 10:4 zero maps directly.
      cfg_q      <= cfg_type'(CFG_RESET[$bits(cfg_type)-1:0]); // [R1]
      amb_q      <= '0;
      int_flag_q <= 1'b0;
      win_prev_q <= 1'b0;
      ev_q       <= 1'b0;
      rdata_q    <= 16'h0000;
      rdv_q      <= 1'b0;
    end else if (i_ce) begin
      cfg_q      <= cfg_d;
      amb_q      <= amb_d;
      int_flag_q <= int_flag_d;
      win_prev_q <= win_prev_d;
      ev_q       <= ev_d;
      rdata_q    <= rdata_d;
      rdv_q      <= rdv_d;
    end
  end

  assign o_rdata              = rdata_q;
  assign o_rd_valid           = rdv_q && i_ce;
  assign o_conv_enable        = !cfg_q.shutdown_select; // [R7]
  assign o_ambient_temp_value = amb_q;
  assign o_crit_lock          = cfg_q.crit_lock;
  assign o_win_lock           = cfg_q.win_lock;
  assign o_event              = cfg_q.ev_pol ? ev_q : !ev_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_cfg_write;
    i_ce && cfg_wr;
  endsequence

  chk_unused_zero: assert property (rdv_q |-> rdata_q[15:11] == 5'h00) // [R1]
    else $error("Unused config bits read nonzero");
  chk_hyst_decode: assert property ( // [R2] [R3]
    (cfg_q.hyst == HC_NONE) == (hyst_amount == HYST_0P0)
      && (cfg_q.hyst != HC_1P5 || hyst_amount == HYST_1P5)
      && (cfg_q.hyst != HC_3P0 || hyst_amount == HYST_3P0))
    else $error("Hysteresis decode wrong");
  chk_hyst_locked: assert property (s_cfg_write ##0 locked |=> $stable(cfg_q.hyst)) // [R4]
    else $error("Hysteresis changed while locked");
  chk_hyst_open: assert property ( // [R5]
    s_cfg_write ##0 !locked |=> cfg_q.hyst == $past(i_wdata[HYST_HI:HYST_LO]))
    else $error("Unlocked hysteresis write lost");
  chk_shutdown_select_refused: assert property ( // [R9]
    s_cfg_write ##0 (locked && !cfg_q.shutdown_select) |=> !cfg_q.shutdown_select)
    else $error("Shutdown entered while locked");
  chk_shutdown_select_hold: assert property ( // [R9]
    s_cfg_write ##0 (locked && i_wdata[SHUTDOWN_SELECT_BIT]) |=> cfg_q.shutdown_select == $past(cfg_q.shutdown_select))
    else $error("Locked shutdown write changed mode");
  chk_shutdown_select_set: assert property ( // [R6]
    s_cfg_write ##0 (!locked && i_wdata[SHUTDOWN_SELECT_BIT]) |=> cfg_q.shutdown_select && !o_conv_enable)
    else $error("Unlocked shutdown write lost");
  chk_shutdown_select_clear: assert property ( // [R10] [R6]
    s_cfg_write ##0 !i_wdata[SHUTDOWN_SELECT_BIT] |=> !cfg_q.shutdown_select ##0 o_conv_enable)
    else $error("Shutdown clear refused");
  chk_event_off: assert property (cfg_q.shutdown_select [*2] |-> !ev_q && o_event == !cfg_q.ev_pol) // [R8]
    else $error("Event asserted in shutdown");
  chk_amb_hold: assert property (cfg_q.shutdown_select && i_conv_valid |=> $stable(amb_q)) // [R11]
    else $error("Ambient updated in shutdown");
  chk_conv_stop: assert property (o_conv_enable != cfg_q.shutdown_select) // [R7]
    else $error("Conversion enable mismatch");
endmodule
`default_nettype wire

// ### hw/sensor_cfg_pkg.sv
// Purpose: Shared constants and types for the sensor configuration word.
// Assumes: Temperatures are signed 16-bit values in steps of 1/16 degree.
// Notes:   Offsets, field positions and reset values live here only.
// Functional notes
// [R1] 16-bit config word at pointer 01, resets zero
// [R2] Hysteresis codes 01/10/11 give 1.5/3.0/6.0 degrees
// [R3] Hysteresis code 00 means no hysteresis
// [R4] Hysteresis writes ignored while either lock set
// [R5] Hysteresis writable in shutdown when unlocked
// [R6] Bit 8: 0 continuous, 1 shutdown
// [R7] Shutdown halts conversions, register access continues
// [R8] Event output deasserted throughout shutdown; the code deasserts it from the second cycle of shutdown, as ev_q is registered
// [R9] Setting shutdown refused while either lock set
// [R10] Clearing shutdown always accepted
// [R11] Ambient value held during shutdown
// [R12] Hysteresis widens event boundary comparisons
package sensor_cfg_pkg;
  localparam int          TEMP_W      = 16;
  localparam logic [7:0]  CFG_PTR     = 8'h01;
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam int          HYST_HI     = 10;
  localparam int          HYST_LO     = 9;
  localparam int          SHUTDOWN_SELECT_BIT    = 8;
  localparam int          CRIT_LK_BIT = 7;
  localparam int          WIN_LK_BIT  = 6;
  localparam int          INT_CLR_BIT = 5;
  localparam int          EV_STAT_BIT = 4;
  localparam int          EV_EN_BIT   = 3;
  localparam int          EV_SEL_BIT  = 2;
  localparam int          EV_POL_BIT  = 1;
  localparam int          EV_MODE_BIT = 0;
  // Hysteresis amounts in 1/16 degree steps.
  localparam logic [TEMP_W-1:0] HYST_0P0 = 16'h0000;
  localparam logic [TEMP_W-1:0] HYST_1P5 = 16'h0018;
  localparam logic [TEMP_W-1:0] HYST_3P0 = 16'h0030;
  localparam logic [TEMP_W-1:0] HYST_6P0 = 16'h0060;
  localparam logic [1:0] HC_NONE = 2'h0;
  localparam logic [1:0] HC_1P5  = 2'h1;
  localparam logic [1:0] HC_3P0  = 2'h2;

  typedef struct packed {
    logic [1:0] hyst;
    logic       shutdown_select;
    logic       crit_lock;
    logic       win_lock;
    logic       ev_en;
    logic       ev_sel;
    logic       ev_pol;
    logic       ev_mode;
  } cfg_type;

  typedef struct packed {
    logic [TEMP_W-1:0] upper;
    logic [TEMP_W-1:0] lower;
    logic [TEMP_W-1:0] crit;
  } limits_type;
endpackage

// ### hw/hyst_comparator.sv
// Purpose: One limit comparator with a hysteresis band on release.
// Assumes: Temperature and limit are signed and share one scale.
// Notes:   Trips past the limit, releases only past limit minus hysteresis (limit plus hysteresis for a lower limit).
`timescale 1ns/1ps
`default_nettype none
module hyst_comparator #(
  parameter int W         = 16,
  parameter bit ABOVE     = 1'b1,
  parameter bit INCLUSIVE = 1'b0
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Compare inputs
  input  wire logic [W-1:0] i_temp,
  input  wire logic [W-1:0] i_limit,
  input  wire logic [W-1:0] i_hyst,
  // Result
  output logic              o_trip
);
  logic          trip_q;
  logic          trip_d;
  logic signed [W:0] t_s;
  logic signed [W:0] l_s;
  logic signed [W:0] h_s;
  logic          beyond;
  logic          released;

  always_comb begin
    t_s = {i_temp[W-1], i_temp};
    l_s = {i_limit[W-1], i_limit};
    h_s = {1'b0, i_hyst};
    if (ABOVE) begin
      beyond   = INCLUSIVE ? (t_s >= l_s) : (t_s > l_s);
      released = t_s < (l_s - h_s); // [R12]
    end else begin
      beyond   = INCLUSIVE ? (t_s <= l_s) : (t_s < l_s);
      released = t_s > (l_s + h_s); // [R12]
    end
    trip_d = trip_q;
    if (beyond) begin
      trip_d = 1'b1;
    end else if (released) begin
      trip_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trip_q <= 1'b0;
    end else if (i_ce) begin
      trip_q <= trip_d;
    end
  end

  assign o_trip = trip_q;
endmodule
`default_nettype wire

// ### dv/cfg_host.sv
// Purpose: Register port host issuing one-cycle write and read strobes.
// Assumes: Strobes are taken on the rising edge; read data returns with valid.
// Notes:   A read gives up after eight cycles without valid.
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  // Clock
  input  wire logic        i_clk,
  // Register port
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rd_valid,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_ptr,
  output logic [15:0]      o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_ptr   = 8'h00;
    o_wdata = 16'h0000;
  end

  // Released lines show the inverse so stale values are never mistaken.
  task automatic write_word(input logic [7:0] ptr, input logic [15:0] data);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_ptr   <= ptr;
    o_wdata <= data;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_ptr   <= ~ptr;
    o_wdata <= ~data;
  endtask

  task automatic read_word(input logic [7:0] ptr, output logic [15:0] data, output bit ok);
    ok   = 1'b0;
    data = 16'h0000;
    @(posedge i_clk);
    o_rd  <= 1'b1;
    o_ptr <= ptr;
    @(posedge i_clk);
    o_rd  <= 1'b0;
    o_ptr <= ~ptr;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge i_clk);
      if (i_rd_valid === 1'b1) begin
        ok   = 1'b1;
        data = i_rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Purpose: Self-checking bench for the sensor configuration register.
// Assumes: Temperatures in sixteenths of a degree.
// Notes:   Lock bits are set last, since only reset clears them.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
  import sensor_cfg_pkg::*;
  typedef struct packed {
    logic [15:0] wd;
    logic [15:0] rexp;
    logic        cen;
  } row_type;
  localparam row_type ROWS [6] = '{'{16'h0600, 16'h0600, 1'b1}, '{16'h0200, 16'h0200, 1'b1},
    '{16'h0400, 16'h0400, 1'b1}, '{16'hf82e, 16'h000e, 1'b1},
    '{16'h0300, 16'h0300, 1'b0}, '{16'h0000, 16'h0000, 1'b1}};
  // Hysteresis of 0, 1.5, 3.0 and 6.0 degrees in sixteenths.
  localparam logic [15:0] HYS [4] = '{16'h0000, 16'h0018, 16'h0030, 16'h0060};
  logic        i_clk;
  logic        i_rst;
  logic        wr;
  logic        rd_stb;
  logic        ce;
  logic [7:0]  ptr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rd_valid;
  logic        conv_valid;
  logic [15:0] conv_temp;
  limits_type  limits;
  logic        conv_en;
  logic [15:0] amb;
  logic        crit_lk;
  logic        win_lk;
  logic        ev;
  logic [15:0] rv;
  bit          ok;
  int          error_cnt;
  int          samples_checked;

  sensor_config_register dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_wr(wr),
    .i_rd(rd_stb), .i_ptr(ptr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .i_conv_valid(conv_valid), .i_conv_temp(conv_temp), .i_limits(limits),
    .o_conv_enable(conv_en), .o_ambient_temp_value(amb), .o_crit_lock(crit_lk),
    .o_win_lock(win_lk), .o_event(ev));
  cfg_host host (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_wr(wr),
    .o_rd(rd_stb), .o_ptr(ptr), .o_wdata(wdata));

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] p);
    host.read_word(p, rv, ok);
    if (!ok) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic sample(input logic [15:0] t);
    @(posedge i_clk);
    conv_valid <= 1'b1;
    conv_temp  <= t;
    @(posedge i_clk);
    conv_valid <= 1'b0;
    conv_temp  <= ~t;
    repeat (4) @(posedge i_clk);
    #2;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    i_rst      = 1'b1;
    ce         = 1'b1;
    conv_valid = 1'b0;
    conv_temp  = 16'h0000;
    limits     = '{upper: 16'h0100, lower: 16'h0000, crit: 16'h0400};
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    #2;
    `CHECK({conv_en, ev, crit_lk, win_lk, amb}, {4'hc, 16'h0000})
    rd(CFG_PTR);
    `CHECK(rv, 16'h0000)
    host.write_word(8'h02, 16'h0100);
    rd(8'h02);
    `CHECK({rv, conv_en}, {16'h0000, 1'b1})
    for (int i = 0; i < 6; i++) begin
      host.write_word(CFG_PTR, ROWS[i].wd);
      rd(CFG_PTR);
      `CHECK({rv, conv_en}, {ROWS[i].rexp, ROWS[i].cen})
    end
    // A write while the clock enable is low must leave the word untouched.
    @(posedge i_clk);
    ce <= 1'b0;
    host.write_word(CFG_PTR, 16'h0600);
    @(posedge i_clk);
    ce <= 1'b1;
    rd(CFG_PTR);
    `CHECK({rv, conv_en}, {16'h0000, 1'b1})
    for (int c = 0; c < 4; c++) begin
      host.write_word(CFG_PTR, 16'h000a | (16'(c) << 9));
      sample(16'h0120);
      `CHECK(ev, 1'b1)
      sample(16'h0100 - HYS[c]);
      `CHECK(ev, 1'b1)
      sample(16'h00ff - HYS[c]);
      `CHECK(ev, 1'b0)
    end
    sample(16'h0120);
    host.write_word(CFG_PTR, 16'h010a);
    repeat (3) @(posedge i_clk);
    #2;
    `CHECK({ev, conv_en}, 2'b00)
    sample(16'h0050);
    `CHECK({amb, ev}, {16'h0120, 1'b0})
    rd(CFG_PTR);
    `CHECK(rv, 16'h010a)
    host.write_word(CFG_PTR, 16'h0300);
    host.write_word(CFG_PTR, 16'h0380);
    rd(CFG_PTR);
    `CHECK({rv, crit_lk}, {16'h0380, 1'b1})
    host.write_word(CFG_PTR, 16'h0080);
    rd(CFG_PTR);
    `CHECK({rv, conv_en}, {16'h0280, 1'b1})
    sample(16'h0050);
    `CHECK(amb, 16'h0050)
    host.write_word(CFG_PTR, 16'h0180);
    rd(CFG_PTR);
    `CHECK({rv, conv_en}, {16'h0280, 1'b1})
    host.write_word(CFG_PTR, 16'h0044);
    host.write_word(CFG_PTR, 16'h0000);
    rd(CFG_PTR);
    `CHECK({rv, win_lk}, {16'h02c4, 1'b1})
    // Only reset clears the lock bits.
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(CFG_PTR);
    `CHECK({rv, crit_lk, win_lk, conv_en}, {16'h0000, 3'b001})
    complete_run();
  end
endmodule
`default_nettype wire
